// File: rtl/port_def_pin_function_select.sv
// pin function and pull-up selection for ports d, e and f
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module port_def_pin_function_select (
  // clock and power-on reset
  input  wire logic                      clock,
  input  wire logic                      reset,
  // device pins
  input  wire logic                      powerOnResetIn,
  input  wire logic                      manualResetIn,
  input  wire logic                      debugModeStrap,
  // axi4-lite write address and data
  input  wire logic [7:0]                awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  // axi4-lite write response
  output logic [1:0]                     bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  // axi4-lite read
  input  wire logic [7:0]                araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  // pad controls
  output var pin_select_pkg::pin_ctrl_t  portDCtrl,
  output var pin_select_pkg::pin_ctrl_t  portECtrl,
  output var pin_select_pkg::pin_ctrl_t  portFCtrl
);
  import pin_select_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic porMeta_r, porMeta_nxt, porSync_r, porSync_nxt;
  logic manMeta_r, manMeta_nxt, manSync_r, manSync_nxt;
  logic strapMeta_r, strapMeta_nxt, strapSync_r, strapSync_nxt;

  // only the second stage of each pair reads the first
  always_comb begin
    porMeta_nxt   = powerOnResetIn;
    porSync_nxt   = porMeta_r;
    manMeta_nxt   = manualResetIn;
    manSync_nxt   = manMeta_r;
    strapMeta_nxt = debugModeStrap;
    strapSync_nxt = strapMeta_r;
  end

  // no reset on these: they must follow the pins during reset
  always_ff @(posedge clock) begin
    porMeta_r   <= porMeta_nxt;
    porSync_r   <= porSync_nxt;
    manMeta_r   <= manMeta_nxt;
    manSync_r   <= manSync_nxt;
    strapMeta_r <= strapMeta_nxt;
    strapSync_r <= strapSync_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // reset domains

  logic porActive;
  logic busReset;

  // manual reset only clears the bus side, selectors keep their value
  assign porActive = reset | porSync_r;
  assign busReset  = porActive | manSync_r;

  ////////////////////////////////////////////////////////////////////////////////
  // strap capture

  logic debugMode_r, debugMode_nxt;
  logic porSeen_r, porSeen_nxt;

  always_comb begin
    debugMode_nxt = debugMode_r;
    porSeen_nxt   = porSeen_r;
    if (porActive) begin
      debugMode_nxt = ~strapSync_r;
      porSeen_nxt   = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    debugMode_r <= debugMode_nxt;
    porSeen_r   <= porSeen_nxt;
  end

  logic [31:0] statusWord;

  always_comb begin
    statusWord                   = 32'h0000_0000;
    statusWord[STATUS_DEBUG_BIT] = debugMode_r;
    statusWord[STATUS_POR_BIT]   = porSeen_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strap-dependent power-on values

  logic [15:0] portEReset;
  logic [15:0] portFReset;

  // strap high is normal mode
  assign portEReset = strapSync_r ? PORT_E_RESET_NORMAL : PORT_E_RESET_DEBUG;
  assign portFReset = strapSync_r ? PORT_F_RESET_NORMAL : PORT_F_RESET_DEBUG;

  ////////////////////////////////////////////////////////////////////////////////
  // bus front end

  reg_write_t  regWr;
  logic        wrMiss;
  logic [31:0] rdValue;
  logic        rdMiss;

  axil_reg_slave u_bus (
    .clock   (clock),
    .reset   (busReset),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .regWr   (regWr),
    .wrMiss  (wrMiss),
    .rdValue (rdValue),
    .rdMiss  (rdMiss)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // selector registers

  logic [15:0] portDSel_r, portDSel_nxt;
  logic [15:0] portESel_r, portESel_nxt;
  logic [15:0] portFSel_r, portFSel_nxt;

  // only the two low byte lanes carry selector bits
  function automatic logic [15:0] mergeLanes(
    input logic [15:0] old,
    input logic [31:0] data,
    input logic [3:0]  strb
  );
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  logic wrD, wrE, wrF;

  assign wrD    = regWr.wrEn & (regWr.wrAddr == ADDR_PORT_D);
  assign wrE    = regWr.wrEn & (regWr.wrAddr == ADDR_PORT_E);
  assign wrF    = regWr.wrEn & (regWr.wrAddr == ADDR_PORT_F);
  // status is read-only, so a write there is refused too
  assign wrMiss = ~(wrD | wrE | wrF);

  always_comb begin
    portDSel_nxt = portDSel_r;
    portESel_nxt = portESel_r;
    portFSel_nxt = portFSel_r;
    if (porActive) begin
      portDSel_nxt = PORT_D_RESET;
      portESel_nxt = portEReset;
      portFSel_nxt = portFReset;
    end else begin
      // reserved codes are stored as written, decode gives them no drive
      if (wrD) begin
        portDSel_nxt = mergeLanes(portDSel_r, regWr.wrData, regWr.wrStrb);
      end
      if (wrE) begin
        portESel_nxt = mergeLanes(portESel_r, regWr.wrData, regWr.wrStrb);
      end
      if (wrF) begin
        portFSel_nxt = mergeLanes(portFSel_r, regWr.wrData, regWr.wrStrb);
      end
    end
  end

  // no manual reset term here on purpose
  always_ff @(posedge clock) begin
    portDSel_r <= portDSel_nxt;
    portESel_r <= portESel_nxt;
    portFSel_r <= portFSel_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read mux

  always_comb begin
    rdValue = 32'h0000_0000;
    rdMiss  = 1'b0;
    case (araddr)
      ADDR_PORT_D: rdValue[15:0] = portDSel_r;
      ADDR_PORT_E: rdValue[15:0] = portESel_r;
      ADDR_PORT_F: rdValue[15:0] = portFSel_r;
      ADDR_STATUS: rdValue = statusWord;
      default: rdMiss = 1'b1;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pad decode

  pin_ctrl_t portDDec, portEDec, portFDec;

  pin_field_decode #(
    .OUT_OK (PORT_D_OUT_OK),
    .ALT_OK (PORT_D_ALT_OK)
  ) u_decD (
    .sel  (portDSel_r),
    .ctrl (portDDec)
  );

  pin_field_decode #(
    .OUT_OK (PORT_E_OUT_OK),
    .ALT_OK (PORT_E_ALT_OK)
  ) u_decE (
    .sel  (portESel_r),
    .ctrl (portEDec)
  );

  pin_field_decode #(
    .OUT_OK (PORT_F_OUT_OK),
    .ALT_OK (PORT_F_ALT_OK)
  ) u_decF (
    .sel  (portFSel_r),
    .ctrl (portFDec)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // pad control registers

  // one cycle behind the selector; avoids decode glitches on pads
  pin_ctrl_t portDCtrl_r, portDCtrl_nxt;
  pin_ctrl_t portECtrl_r, portECtrl_nxt;
  pin_ctrl_t portFCtrl_r, portFCtrl_nxt;

  always_comb begin
    portDCtrl_nxt = portDDec;
    portECtrl_nxt = portEDec;
    portFCtrl_nxt = portFDec;
  end

  always_ff @(posedge clock) begin
    portDCtrl_r <= portDCtrl_nxt;
    portECtrl_r <= portECtrl_nxt;
    portFCtrl_r <= portFCtrl_nxt;
  end

  assign portDCtrl = portDCtrl_r;
  assign portECtrl = portECtrl_r;
  assign portFCtrl = portFCtrl_r;

endmodule

`default_nettype wire

// File: rtl/pin_select_pkg.sv
// shared constants and types for the port d/e/f pin function selector
package pin_select_pkg;

  localparam int PIN_COUNT = 8;
  localparam int SEL_W     = 16;
  localparam int ADDR_W    = 8;

  // register byte addresses
  localparam logic [7:0] ADDR_PORT_D = 8'h00;
  localparam logic [7:0] ADDR_PORT_E = 8'h04;
  localparam logic [7:0] ADDR_PORT_F = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // power-on values
  localparam logic [15:0] PORT_D_RESET        = 16'haa8a;
  localparam logic [15:0] PORT_E_RESET_NORMAL = 16'haaaa;
  localparam logic [15:0] PORT_E_RESET_DEBUG  = 16'h2aa8;
  localparam logic [15:0] PORT_F_RESET_NORMAL = 16'haaaa;
  localparam logic [15:0] PORT_F_RESET_DEBUG  = 16'h00aa;

  // per-pin field codes
  localparam logic [1:0] CODE_ALT      = 2'h0;
  localparam logic [1:0] CODE_OUT      = 2'h1;
  localparam logic [1:0] CODE_PULL_ON  = 2'h2;
  localparam logic [1:0] CODE_PULL_OFF = 2'h3;

  // pins where output / alternate function exist
  localparam logic [7:0] PORT_D_OUT_OK = 8'haf;
  localparam logic [7:0] PORT_D_ALT_OK = 8'hff;
  localparam logic [7:0] PORT_E_OUT_OK = 8'hff;
  localparam logic [7:0] PORT_E_ALT_OK = 8'h34;
  localparam logic [7:0] PORT_F_OUT_OK = 8'h00;
  localparam logic [7:0] PORT_F_ALT_OK = 8'hff;

  // status register fields
  localparam int STATUS_DEBUG_BIT = 0;
  localparam int STATUS_POR_BIT   = 1;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [7:0] altSel;
    logic [7:0] outEn;
    logic [7:0] pullUpEn;
  } pin_ctrl_t;

  typedef struct packed {
    logic        wrEn;
    logic [7:0]  wrAddr;
    logic [31:0] wrData;
    logic [3:0]  wrStrb;
  } reg_write_t;

endpackage

// File: rtl/pin_field_decode.sv
// decodes one 16-bit selector into per-pin pad controls
`timescale 1ns/1ps
`default_nettype none

module pin_field_decode #(
  parameter logic [7:0] OUT_OK = 8'hff,
  parameter logic [7:0] ALT_OK = 8'hff
) (
  // selector value
  input  wire logic [15:0]               sel,
  // decoded pad controls
  output var  pin_select_pkg::pin_ctrl_t ctrl
);
  import pin_select_pkg::*;

  logic [7:0] pinSelHi;
  logic [7:0] pinSelLo;

  genvar n;
  generate
    for (n = 0; n < PIN_COUNT; n++) begin : g_pin
      assign pinSelHi[n] = sel[2*n+1];
      assign pinSelLo[n] = sel[2*n];
      // reserved codes drive nothing
      assign ctrl.pullUpEn[n] = ({pinSelHi[n], pinSelLo[n]} == CODE_PULL_ON);
      assign ctrl.outEn[n]    = ({pinSelHi[n], pinSelLo[n]} == CODE_OUT) & OUT_OK[n];
      assign ctrl.altSel[n]   = ({pinSelHi[n], pinSelLo[n]} == CODE_ALT) & ALT_OK[n];
    end
  endgenerate

endmodule

`default_nettype wire

// File: rtl/axil_reg_slave.sv
// axi4-lite slave front end: one write and one read at a time
`timescale 1ns/1ps
`default_nettype none

module axil_reg_slave (
  // clock and reset
  input  wire logic                       clock,
  input  wire logic                       reset,
  // write address and data
  input  wire logic [7:0]                 awaddr,
  input  wire logic                       awvalid,
  output logic                            awready,
  input  wire logic [31:0]                wdata,
  input  wire logic [3:0]                 wstrb,
  input  wire logic                       wvalid,
  output logic                            wready,
  // write response
  output logic [1:0]                      bresp,
  output logic                            bvalid,
  input  wire logic                       bready,
  // read
  input  wire logic [7:0]                 araddr,
  input  wire logic                       arvalid,
  output logic                            arready,
  output logic [31:0]                     rdata,
  output logic [1:0]                      rresp,
  output logic                            rvalid,
  input  wire logic                       rready,
  // register file side
  output var  pin_select_pkg::reg_write_t regWr,
  input  wire logic                       wrMiss,
  input  wire logic [31:0]                rdValue,
  input  wire logic                       rdMiss
);
  import pin_select_pkg::*;

  logic        awHeld_r, awHeld_nxt, wHeld_r, wHeld_nxt;
  logic [7:0]  addr_r, addr_nxt;
  logic [31:0] data_r, data_nxt;
  logic [3:0]  strb_r, strb_nxt;
  logic        bValid_r, bValid_nxt, awRdy_r, awRdy_nxt, wRdy_r, wRdy_nxt;
  logic [1:0]  bResp_r, bResp_nxt;
  logic        rValid_r, rValid_nxt, arRdy_r, arRdy_nxt;
  logic [31:0] rData_r, rData_nxt;
  logic [1:0]  rResp_r, rResp_nxt;
  logic        doWrite;

  assign doWrite       = awHeld_r & wHeld_r & ~bValid_r;
  assign regWr.wrEn    = doWrite;
  assign regWr.wrAddr  = addr_r;
  assign regWr.wrData  = data_r;
  assign regWr.wrStrb  = strb_r;

  always_comb begin
    awHeld_nxt = awHeld_r;
    wHeld_nxt  = wHeld_r;
    addr_nxt   = addr_r;
    data_nxt   = data_r;
    strb_nxt   = strb_r;
    bValid_nxt = bValid_r;
    bResp_nxt  = bResp_r;
    if (awvalid & awRdy_r) begin
      awHeld_nxt = 1'b1;
      addr_nxt   = awaddr;
    end
    if (wvalid & wRdy_r) begin
      wHeld_nxt = 1'b1;
      data_nxt  = wdata;
      strb_nxt  = wstrb;
    end
    if (doWrite) begin
      awHeld_nxt = 1'b0;
      wHeld_nxt  = 1'b0;
      bValid_nxt = 1'b1;
      bResp_nxt  = wrMiss ? RESP_SLVERR : RESP_OKAY;
    end else if (bValid_r & bready) begin
      bValid_nxt = 1'b0;
    end
    awRdy_nxt = ~awHeld_nxt & ~bValid_nxt;
    wRdy_nxt  = ~wHeld_nxt & ~bValid_nxt;
    // read answers straight from the address, no wait state
    rValid_nxt = rValid_r;
    rData_nxt  = rData_r;
    rResp_nxt  = rResp_r;
    if (arvalid & arRdy_r) begin
      rValid_nxt = 1'b1;
      rData_nxt  = rdValue;
      rResp_nxt  = rdMiss ? RESP_SLVERR : RESP_OKAY;
    end else if (rValid_r & rready) begin
      rValid_nxt = 1'b0;
    end
    arRdy_nxt = ~rValid_nxt;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      awHeld_r <= 1'b0;
      wHeld_r  <= 1'b0;
      addr_r   <= 8'h00;
      data_r   <= 32'h0000_0000;
      strb_r   <= 4'h0;
      bValid_r <= 1'b0;
      bResp_r  <= RESP_OKAY;
      awRdy_r  <= 1'b0;
      wRdy_r   <= 1'b0;
      rValid_r <= 1'b0;
      rData_r  <= 32'h0000_0000;
      rResp_r  <= RESP_OKAY;
      arRdy_r  <= 1'b0;
    end else begin
      awHeld_r <= awHeld_nxt;
      wHeld_r  <= wHeld_nxt;
      addr_r   <= addr_nxt;
      data_r   <= data_nxt;
      strb_r   <= strb_nxt;
      bValid_r <= bValid_nxt;
      bResp_r  <= bResp_nxt;
      awRdy_r  <= awRdy_nxt;
      wRdy_r   <= wRdy_nxt;
      rValid_r <= rValid_nxt;
      rData_r  <= rData_nxt;
      rResp_r  <= rResp_nxt;
      arRdy_r  <= arRdy_nxt;
    end
  end

  assign awready = awRdy_r;
  assign wready  = wRdy_r;
  assign bvalid  = bValid_r;
  assign bresp   = bResp_r;
  assign arready = arRdy_r;
  assign rvalid  = rValid_r;
  assign rdata   = rData_r;
  assign rresp   = rResp_r;

endmodule

`default_nettype wire

// File: verification/pin_select_props.sv
// concurrent checks on the pin function selector ports
`timescale 1ns/1ps
`default_nettype none

module pin_select_props
  import pin_select_pkg::*;
(
  // clock, reset and debug strap
  input wire logic      clock,
  input wire logic      reset,
  input wire logic      debugModeStrap,
  // bus handshakes
  input wire logic      awvalid,
  input wire logic      awready,
  input wire logic      wvalid,
  input wire logic      wready,
  input wire logic      bvalid,
  input wire logic      arvalid,
  input wire logic      arready,
  input wire logic      rvalid,
  // pad controls
  input wire pin_ctrl_t portDCtrl,
  input wire pin_ctrl_t portECtrl,
  input wire pin_ctrl_t portFCtrl
);
  default clocking cb @(posedge clock); endclocking

  // two drives on one pin would fight at the pad
  function automatic logic clash(input pin_ctrl_t c);
    return |((c.altSel & c.outEn) | (c.altSel & c.pullUpEn) | (c.outEn & c.pullUpEn));
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  pads_exclusive_a: assert property (disable iff (reset) !clash(portDCtrl) && !clash(portECtrl)
    && !clash(portFCtrl)) else $error("two drives enabled on one pin");
  no_output_a: assert property (disable iff (reset) portDCtrl.outEn[4] == 1'b0
    && portDCtrl.outEn[6] == 1'b0 && portFCtrl.outEn == 8'h00) else $error("output on pin without output");
  no_alt_a: assert property (disable iff (reset) (portECtrl.altSel & 8'hcb) == 8'h00)
    else $error("alternate select on pin without one");
  d_reset_a: assert property (reset [*3] |=> portDCtrl == {8'h04, 8'h00, 8'hfb})
    else $error("port d pads wrong after reset");
  strap_high_a: assert property ((reset && debugModeStrap) [*5] |=>
    portECtrl == {8'h00, 8'h00, 8'hff} && portFCtrl == {8'h00, 8'h00, 8'hff}) else $error("normal reset pads");
  strap_low_a: assert property ((reset && !debugModeStrap) [*5] |=>
    portECtrl == {8'h00, 8'h00, 8'h7e} && portFCtrl == {8'hf0, 8'h00, 8'h0f}) else $error("debug reset pads");
  read_answer_a: assert property (disable iff (reset) arvalid && arready |=> rvalid)
    else $error("read answer late");
  write_answer_a: assert property (disable iff (reset) awvalid && awready && wvalid && wready
    |-> ##[1:2] bvalid) else $error("write answer late");
endmodule

`default_nettype wire

// File: verification/tb.sv
// self-checking bench for the pin function selector
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end

module tb;
  import pin_select_pkg::*;
  logic        clock = 1'b0, reset = 1'b1, powerOnResetIn = 1'b0, manualResetIn = 1'b0, debugModeStrap = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, awready, wready, arready, bvalid, rvalid;
  logic        bready = 1'b1, rready = 1'b1;
  logic [1:0]  bresp, rresp;
  pin_ctrl_t   portDCtrl, portECtrl, portFCtrl;
  int          n_fail = 0, n_checks = 0, c;
  logic [7:0]  v;

  always #12.5 clock = ~clock;

  port_def_pin_function_select u_dut (.clock(clock), .reset(reset), .powerOnResetIn(powerOnResetIn),
    .manualResetIn(manualResetIn), .debugModeStrap(debugModeStrap), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .portDCtrl(portDCtrl), .portECtrl(portECtrl),
    .portFCtrl(portFCtrl));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    if (n_fail == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er);
    int t;
    t = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      t++;
    end while (bvalid !== 1'b1 && t < 50);
    `CHK(bvalid, 1'b1)
    `CHK(bresp, er)
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int t;
    t = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (arready === 1'b1) arvalid <= 1'b0;
      t++;
    end while (rvalid !== 1'b1 && t < 50);
    `CHK(rvalid, 1'b1)
    `CHK(rdata, ed)
    `CHK(rresp, er)
  endtask

  function automatic pin_ctrl_t dec(input logic [1:0] k, input logic [7:0] outOk, input logic [7:0] altOk);
    dec.altSel = (k == 2'h0) ? altOk : 8'h00;
    dec.outEn = (k == 2'h1) ? outOk : 8'h00;
    dec.pullUpEn = (k == 2'h2) ? 8'hff : 8'h00;
  endfunction

  task automatic por(input logic strap);
    debugModeStrap <= strap;
    reset <= 1'b1;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #100us;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    @(posedge clock);
    por(1'b0);
    axr(ADDR_PORT_D, 32'h0000aa8a, RESP_OKAY);
    axr(ADDR_PORT_E, 32'h00002aa8, RESP_OKAY);
    axr(ADDR_PORT_F, 32'h000000aa, RESP_OKAY);
    axr(ADDR_STATUS, 32'h00000003, RESP_OKAY);
    // every code on every pin, reserved ones read back but never drive
    for (c = 0; c < 4; c++) begin
      v = {4{c[1:0]}};
      axw(ADDR_PORT_D, {16'h0, v, v}, 4'h3, RESP_OKAY);
      axw(ADDR_PORT_E, {16'h0, v, v}, 4'h3, RESP_OKAY);
      axw(ADDR_PORT_F, {16'hffff, v, v}, 4'hf, RESP_OKAY);
      axr(ADDR_PORT_D, {16'h0, v, v}, RESP_OKAY);
      axr(ADDR_PORT_E, {16'h0, v, v}, RESP_OKAY);
      axr(ADDR_PORT_F, {16'h0, v, v}, RESP_OKAY);
      @(posedge clock);
      #1;
      `CHK({portDCtrl, portECtrl, portFCtrl}, {dec(c[1:0], 8'haf, 8'hff), dec(c[1:0], 8'hff, 8'h34), dec(c[1:0], 8'h00, 8'hff)})
    end
    // upper byte lane alone
    axw(ADDR_PORT_D, 32'hffff1200, 4'h2, RESP_OKAY);
    axr(ADDR_PORT_D, 32'h000012ff, RESP_OKAY);
    axw(8'h10, 32'h0, 4'hf, RESP_SLVERR);
    axr(8'h10, 32'h0, RESP_SLVERR);
    axw(ADDR_PORT_F, 32'h00008e3b, 4'h3, RESP_OKAY);
    // manual reset reaches the bus only
    manualResetIn <= 1'b1;
    repeat (4) @(posedge clock);
    manualResetIn <= 1'b0;
    repeat (6) @(posedge clock);
    axr(ADDR_PORT_D, 32'h000012ff, RESP_OKAY);
    axr(ADDR_PORT_E, 32'h0000ffff, RESP_OKAY);
    axr(ADDR_PORT_F, 32'h00008e3b, RESP_OKAY);
    por(1'b1);
    axr(ADDR_PORT_D, 32'h0000aa8a, RESP_OKAY);
    axr(ADDR_PORT_E, 32'h0000aaaa, RESP_OKAY);
    axr(ADDR_PORT_F, 32'h0000aaaa, RESP_OKAY);
    axr(ADDR_STATUS, 32'h00000002, RESP_OKAY);
    // power-on reset through the pin, strap low
    axw(ADDR_PORT_D, 32'h00005555, 4'h3, RESP_OKAY);
    debugModeStrap <= 1'b0;
    powerOnResetIn <= 1'b1;
    repeat (6) @(posedge clock);
    powerOnResetIn <= 1'b0;
    repeat (4) @(posedge clock);
    axr(ADDR_PORT_D, 32'h0000aa8a, RESP_OKAY);
    axr(ADDR_PORT_E, 32'h00002aa8, RESP_OKAY);
    axr(ADDR_PORT_F, 32'h000000aa, RESP_OKAY);
    axr(ADDR_STATUS, 32'h00000003, RESP_OKAY);
    tally_and_finish();
  end
endmodule

bind port_def_pin_function_select pin_select_props u_props (.clock, .reset, .debugModeStrap, .awvalid,
  .awready, .wvalid, .wready, .bvalid, .arvalid, .arready, .rvalid, .portDCtrl, .portECtrl, .portFCtrl);

`default_nettype wire
